// File: core/ext_bus_consts.svh
// Constants for the external bus pin multiplexer
// Function
// - Any internal reset source drives the reset pin low.
// - Outside low on reset pin resets all internal logic except pin synchronisers and stretch count.
// - Reset pin only sinks low; pull-up gives the high level.
// - Bus mode: port 0 carries low address, then data both ways.
// - Bus mode: port 1 drives the high address byte.
// - Bus mode with enable: port 2 bit 0 is buffer control.
// - Bus mode with enable: port 2 bit 1 is hold acknowledge.
// - Bus mode with enable: port 2 bit 2 takes hold request.
// - Bus mode: port 2 bit 5 is the write strobe.
// - Bus mode: port 2 bit 6 is the read strobe.
// - Bus mode: port 2 bit 7 is the address latch strobe.
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH
`define P2_BUFCTL_BIT 3'd0
`define P2_HACK_BIT   3'd1
`define P2_HREQ_BIT   3'd2
`define P2_RDY_BIT    3'd3
`define P2_CLK_BIT    3'd4
`define P2_WR_BIT     3'd5
`define P2_RD_BIT     3'd6
`define P2_ALE_BIT    3'd7
`define MODE_EXT_BUS  2'h1
`define MODE_SINGLE   2'h0
`define RST_STRETCH   4'h8
`endif

// File: core/ext_bus_pin_mux.sv
// External bus pin multiplexer for ports 0, 1 and 2 and the reset pin
`include "ext_bus_consts.svh"
`timescale 1ns/1ps
module ext_bus_pin_mux (
    input  wire logic        mclk_i,       // 125 MHz system clock
    input  wire logic        rst_n_i,      // Synchronous reset, active low
    input  wire logic        int_rst_i,    // Internal reset request
    output logic             sys_rst_n_o,  // Reset to the rest of the chip
    input  wire logic        rst_pin_i,    // Reset pin level
    output logic             rst_pin_o,    // Reset pin output, always 0
    output logic             rst_pin_oe_o, // Reset pin sink enable
    input  wire logic        op_select_pin_a_i, // Mode select pin a
    input  wire logic        op_select_pin_b_i, // Mode select pin b
    output logic             ext_mode_o,   // External bus mode active
    input  wire logic        buf_en_i,     // Buffer control enable
    input  wire logic        hold_en_i,    // Hold function enable
    input  wire logic [7:0]  p0_out_i,     // Port 0 GPIO data
    input  wire logic [7:0]  p0_dir_i,     // Port 0 GPIO direction, 1 out
    input  wire logic [7:0]  p1_out_i,     // Port 1 GPIO data
    input  wire logic [7:0]  p1_dir_i,     // Port 1 GPIO direction, 1 out
    input  wire logic [7:0]  p2_out_i,     // Port 2 general output data
    output logic [7:0]       p0_in_o,      // Port 0 pin level to GPIO
    output logic [7:0]       p1_in_o,      // Port 1 pin level to GPIO
    output logic [7:0]       p2_in_o,      // Port 2 pin level to GPIO
    input  wire logic        req_i,        // CPU bus access request
    input  wire logic        we_i,         // Access is a write
    input  wire logic [15:0] addr_i,       // Access address
    input  wire logic [7:0]  wdata_i,      // Write data
    output logic             ack_o,        // Access done pulse
    output logic [7:0]       rdata_o,      // Read data
    output logic             held_o,       // Bus released to other master
    input  wire logic [7:0]  muxed_addr_data_pins_i,  // Port 0 pins in
    output logic [7:0]       muxed_addr_data_pins_o,  // Port 0 pins out
    output logic [7:0]       muxed_addr_data_pins_oe, // Port 0 enables
    input  wire logic [7:0]  high_address_pins_i,     // Port 1 pins in
    output logic [7:0]       high_address_pins_o,     // Port 1 pins out
    output logic [7:0]       high_address_pins_oe,    // Port 1 enables
    input  wire logic [7:0]  p2_pins_i,    // Port 2 pins in
    output logic [7:0]       p2_pins_o,    // Port 2 pins out
    output logic [7:0]       p2_pins_oe    // Port 2 enables
);
    pin_sync_if sync_bus ();
    logic rst_n;
    ext_bus_pkg::bus_state_t state_r;
    logic        mode_ext_r;
    logic        bclk_r;
    logic [15:0] addr_r;
    logic [7:0]  wdata_r;
    logic [7:0]  rdata_r;
    logic        we_r;
    logic        ack_r;
    logic        ale_r;
    logic        rd_n_r;
    logic        wr_n_r;
    logic        hack_r;
    logic        buf_n_r;
    logic        bus_en;
    logic        hold_req;

    ////////////////////////////////////////////////////////////////////
    pin_sync u_sync (
        .mclk_i    (mclk_i),
        .rst_pin_i (rst_pin_i),
        .hreq_i    (p2_pins_i[`P2_HREQ_BIT]),
        .rdy_i     (p2_pins_i[`P2_RDY_BIT]),
        .sync      (sync_bus.src)
    );

    reset_ctl u_rst (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .int_rst_i   (int_rst_i),
        .sync        (sync_bus.dst),
        .sys_rst_n_o (rst_n),
        .rst_oe_o    (rst_pin_oe_o)
    );

    assign sys_rst_n_o = rst_n;
    assign rst_pin_o   = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Mode sampled every cycle while reset is active; the board keeps the pins fixed
    always_ff @(posedge mclk_i) begin
        if (!rst_n) begin
            mode_ext_r <= ({op_select_pin_b_i, op_select_pin_a_i} == `MODE_EXT_BUS);
        end
    end
    assign ext_mode_o = mode_ext_r;
    assign bus_en     = mode_ext_r;
    assign hold_req   = bus_en && hold_en_i && sync_bus.hold_req;

    // Bus clock: half the system clock, free running in bus mode
    always_ff @(posedge mclk_i) begin
        if (!rst_n || !bus_en) begin
            bclk_r <= 1'b0;
        end else begin
            bclk_r <= !bclk_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer; state moves on bus clock falling edge
    always_ff @(posedge mclk_i) begin
        if (!rst_n) begin
            state_r <= ext_bus_pkg::BUS_IDLE;
            addr_r  <= 16'h0000;
            wdata_r <= 8'h00;
            rdata_r <= 8'h00;
            we_r    <= 1'b0;
            ack_r   <= 1'b0;
            ale_r   <= 1'b0;
            rd_n_r  <= 1'b1;
            wr_n_r  <= 1'b1;
            hack_r  <= 1'b0;
            buf_n_r <= 1'b1;
        end else begin
            ack_r <= 1'b0;
            if (bclk_r) begin
                unique case (state_r)
                    ext_bus_pkg::BUS_IDLE: begin
                        if (hold_req) begin
                            state_r <= ext_bus_pkg::BUS_HOLD;
                            hack_r  <= 1'b1;
                        end else if (req_i && bus_en) begin
                            state_r <= ext_bus_pkg::BUS_ADDR;
                            addr_r  <= addr_i;
                            wdata_r <= wdata_i;
                            we_r    <= we_i;
                            ale_r   <= 1'b1;
                        end
                    end
                    ext_bus_pkg::BUS_ADDR: begin
                        ale_r   <= 1'b0;
                        state_r <= ext_bus_pkg::BUS_DATA;
                        rd_n_r  <= we_r;
                        wr_n_r  <= !we_r;
                        buf_n_r <= 1'b0;
                    end
                    ext_bus_pkg::BUS_DATA: begin
                        if (sync_bus.ready) begin
                            state_r <= ext_bus_pkg::BUS_END;
                            rdata_r <= muxed_addr_data_pins_i;
                            rd_n_r  <= 1'b1;
                            wr_n_r  <= 1'b1;
                            buf_n_r <= 1'b1;
                        end
                    end
                    ext_bus_pkg::BUS_END: begin
                        state_r <= ext_bus_pkg::BUS_IDLE;
                        ack_r   <= 1'b1;
                    end
                    ext_bus_pkg::BUS_HOLD: begin
                        if (!hold_req) begin
                            state_r <= ext_bus_pkg::BUS_IDLE;
                            hack_r  <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    assign ack_o   = ack_r;
    assign rdata_o = rdata_r;
    assign held_o  = hack_r;

    ////////////////////////////////////////////////////////////////////
    // Address phase decode shared by the pin mux and the checks
    function automatic logic addr_phase(input ext_bus_pkg::bus_state_t st);
        return st == ext_bus_pkg::BUS_ADDR;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin multiplexing; ports 0 and 1 float while the bus is held
    always_comb begin
        if (bus_en) begin
            muxed_addr_data_pins_o  = addr_phase(state_r) ? addr_r[7:0] : wdata_r;
            muxed_addr_data_pins_oe = (hack_r || (state_r == ext_bus_pkg::BUS_IDLE)) ? 8'h00 :
                (addr_phase(state_r) || we_r) ? 8'hff : 8'h00;
            high_address_pins_o  = addr_r[15:8];
            high_address_pins_oe = hack_r ? 8'h00 : 8'hff;
            p2_pins_o            = p2_out_i;
            p2_pins_oe           = 8'hff;
            p2_pins_o[`P2_CLK_BIT] = bclk_r;
            p2_pins_o[`P2_WR_BIT]  = wr_n_r;
            p2_pins_o[`P2_RD_BIT]  = rd_n_r;
            p2_pins_o[`P2_ALE_BIT] = ale_r;
            p2_pins_oe[`P2_RDY_BIT] = 1'b0;
            if (buf_en_i) p2_pins_o[`P2_BUFCTL_BIT] = buf_n_r;
            if (hold_en_i) begin
                p2_pins_o[`P2_HACK_BIT]  = !hack_r;
                p2_pins_oe[`P2_HREQ_BIT] = 1'b0;
            end
        end else begin
            muxed_addr_data_pins_o  = p0_out_i;
            muxed_addr_data_pins_oe = p0_dir_i;
            high_address_pins_o     = p1_out_i;
            high_address_pins_oe    = p1_dir_i;
            p2_pins_o               = p2_out_i;
            p2_pins_oe              = 8'hff;
        end
    end

    assign p0_in_o = muxed_addr_data_pins_i;
    assign p1_in_o = high_address_pins_i;
    assign p2_in_o = p2_pins_i;

    ////////////////////////////////////////////////////////////////////
    ale_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ale_r && bus_en) |-> muxed_addr_data_pins_o == addr_r[7:0])
        else $error("Latch strobe without low address on port 0");
    hi_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (bus_en && !hack_r) |-> high_address_pins_oe == 8'hff)
        else $error("High address not driven");
    strobe_excl_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        !(!rd_n_r && !wr_n_r))
        else $error("Read and write strobes both active");
    rd_dir_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (bus_en && !rd_n_r) |-> muxed_addr_data_pins_oe == 8'h00)
        else $error("Port 0 driven during read");
    rdy_stretch_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (state_r == ext_bus_pkg::BUS_DATA && bclk_r && !sync_bus.ready)
        |=> state_r == ext_bus_pkg::BUS_DATA)
        else $error("Cycle not stretched by ready");
    hold_ack_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (hold_req && state_r == ext_bus_pkg::BUS_IDLE && bclk_r) |=> hack_r)
        else $error("Hold request not acknowledged");
    bufctl_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (!bus_en || !buf_en_i) |-> p2_pins_o[`P2_BUFCTL_BIT] == p2_out_i[0])
        else $error("Buffer control out while disabled");

    // Pin only ever sinks; a high drive would fight other reset sources
    rst_sink_only_a: assert property (@(posedge mclk_i)
        rst_pin_o == 1'b0)
        else $error("Reset pin driven high");

    // Stretch keeps the sink on after the source has gone
    rst_stretch_a: assert property (@(posedge mclk_i)
        int_rst_i |=> rst_pin_oe_o)
        else $error("Reset pin sink released too early");

    p0_addr_drv_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (bus_en && addr_phase(state_r) && !hack_r) |-> muxed_addr_data_pins_oe == 8'hff)
        else $error("Low address not driven on port 0");

    p0_wdata_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (bus_en && state_r == ext_bus_pkg::BUS_DATA && we_r)
        |-> (muxed_addr_data_pins_oe == 8'hff && muxed_addr_data_pins_o == wdata_r))
        else $error("Write data not driven on port 0");

    // Another master owns the bus while it is held
    hold_float_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (bus_en && hack_r)
        |-> (muxed_addr_data_pins_oe == 8'h00 && high_address_pins_oe == 8'h00))
        else $error("Bus pins driven while held");

    hreq_input_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (bus_en && hold_en_i) |-> !p2_pins_oe[`P2_HREQ_BIT])
        else $error("Hold request pin driven");

    rdy_input_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        bus_en |-> !p2_pins_oe[`P2_RDY_BIT])
        else $error("Ready pin driven");

    ale_pin_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (bus_en && addr_phase(state_r) && !hack_r) |-> p2_pins_o[`P2_ALE_BIT])
        else $error("Latch strobe missing in address phase");

    rdy_wait_c: cover property (@(posedge mclk_i) disable iff (!rst_n)
        state_r == ext_bus_pkg::BUS_DATA && bclk_r && !sync_bus.ready);
    clk_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        bus_en |=> p2_pins_o[`P2_CLK_BIT] != $past(p2_pins_o[`P2_CLK_BIT]))
        else $error("Bus clock not toggling");
    rd_cycle_c: cover property (@(posedge mclk_i) disable iff (!rst_n)
        !rd_n_r ##[1:20] ack_r);
    wr_cycle_c: cover property (@(posedge mclk_i) disable iff (!rst_n)
        !wr_n_r ##[1:20] ack_r);
    hold_c: cover property (@(posedge mclk_i) disable iff (!rst_n) $rose(hack_r));
endmodule

// File: core/ext_bus_pkg.sv
// Types for the external bus pin multiplexer
package ext_bus_pkg;
    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_DATA,
        BUS_END,
        BUS_HOLD
    } bus_state_t;
endpackage

// File: core/pin_sync.sv
// Three-stage synchronisers for reset, hold request and ready pins
`timescale 1ns/1ps
module pin_sync (
    input  wire logic mclk_i,     // System clock
    input  wire logic rst_pin_i,  // Raw reset pin level
    input  wire logic hreq_i,     // Raw hold request pin
    input  wire logic rdy_i,      // Raw ready pin
    pin_sync_if.src   sync        // Filtered levels
);
    logic [2:0] s_rst;
    logic [2:0] s_hrq;
    logic [2:0] s_rdy;
    logic       rst_q;
    logic       hrq_q;
    logic       rdy_q;

    // Not reset: must keep running while the pin itself holds reset
    always_ff @(posedge mclk_i) begin
        s_rst <= {s_rst[1:0], rst_pin_i};
        s_hrq <= {s_hrq[1:0], hreq_i};
        s_rdy <= {s_rdy[1:0], rdy_i};
    end

    // A change counts once stages two and three agree
    always_ff @(posedge mclk_i) begin
        if (s_rst[1] == s_rst[2]) rst_q <= s_rst[2];
        if (s_hrq[1] == s_hrq[2]) hrq_q <= s_hrq[2];
        if (s_rdy[1] == s_rdy[2]) rdy_q <= s_rdy[2];
    end

    assign sync.rst_pin  = rst_q;
    assign sync.hold_req = hrq_q;
    assign sync.ready    = rdy_q;
endmodule

// File: core/pin_sync_if.sv
// Synchronised pin levels shared between modules
`timescale 1ns/1ps
interface pin_sync_if;
    logic rst_pin;
    logic hold_req;
    logic ready;
    modport src (output rst_pin, output hold_req, output ready);
    modport dst (input rst_pin, input hold_req, input ready);
endinterface

// File: core/reset_ctl.sv
// Reset pin sink and combined internal reset
`include "ext_bus_consts.svh"
`timescale 1ns/1ps
module reset_ctl (
    input  wire logic mclk_i,      // System clock
    input  wire logic rst_n_i,     // Power-on reset, active low
    input  wire logic int_rst_i,   // Internal reset sources, high active
    pin_sync_if.dst   sync,        // Synchronised pin level
    output logic      sys_rst_n_o, // Combined reset, active low
    output logic      rst_oe_o     // Reset pin sink enable
);
    logic [3:0] stretch_r;
    logic       sys_rst_n_r;

    // Stretch keeps the pin low long enough for slow boards
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            stretch_r <= `RST_STRETCH;
        end else if (int_rst_i) begin
            stretch_r <= `RST_STRETCH;
        end else if (stretch_r != 4'h0) begin
            stretch_r <= stretch_r - 4'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        sys_rst_n_r <= rst_n_i && sync.rst_pin;
    end

    assign rst_oe_o    = int_rst_i || (stretch_r != 4'h0) || !rst_n_i;
    assign sys_rst_n_o = sys_rst_n_r;

    sink_on_int_a: assert property (@(posedge mclk_i) int_rst_i |-> rst_oe_o)
        else $error("Reset pin not sunk on internal reset");
    pin_low_rst_a: assert property (@(posedge mclk_i)
        (rst_n_i && !sync.rst_pin) |=> !sys_rst_n_o)
        else $error("Low reset pin did not reset logic");
endmodule

// File: sim/bus_mem_model.sv
// Behavioural external memory on the multiplexed address and data bus
`timescale 1ns/1ps
module bus_mem_model (
    input  wire logic        mclk_i,       // System clock
    input  wire logic        ale_i,        // Address latch strobe, high
    input  wire logic        rd_n_i,       // Read strobe, active low
    input  wire logic        wr_n_i,       // Write strobe, active low
    input  wire logic [7:0]  ad_i,         // Resolved port 0 level
    input  wire logic [7:0]  a_hi_i,       // Resolved port 1 level
    input  wire logic [3:0]  wait_i,       // Cycles ready stays low
    output logic [7:0]       ad_o,         // Read data drive
    output logic             ad_en_o,      // Read data enable
    output logic             rdy_o,        // Ready, high when done
    output logic [15:0]      last_addr_o,  // Last latched address
    output logic [7:0]       last_wdata_o  // Last written byte
);
    logic [7:0] mem [256];
    logic [3:0] wcnt_r;
    initial begin
        last_addr_o = 16'h0000;
        last_wdata_o = 8'h00;
        wcnt_r = 4'h0;
    end
    always @(posedge mclk_i) begin
        if (ale_i) begin
            last_addr_o <= {a_hi_i, ad_i};
        end
        if (!wr_n_i) begin
            last_wdata_o <= ad_i;
            mem[last_addr_o[7:0]] <= ad_i;
        end
        if (rd_n_i && wr_n_i) begin
            wcnt_r <= 4'h0;
        end else if (wcnt_r != 4'hF) begin
            wcnt_r <= wcnt_r + 4'h1;
        end
    end
    // Slow device: ready low until the wait count has run out
    // Slow setting parks ready low between cycles, so no stale high is synced
    assign rdy_o = (wait_i == 4'h0) || (!(rd_n_i && wr_n_i) && (wcnt_r >= wait_i));
    assign ad_en_o = !rd_n_i;
    assign ad_o = mem[last_addr_o[7:0]];
endmodule

// File: sim/tb.sv
// Self-checking bench for the external bus pin multiplexer
`timescale 1ns/1ps
module tb;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, int_rst_i = 1'b0, pin_low = 1'b0;
    logic sel_a = 1'b0, sel_b = 1'b0, buf_en = 1'b1, hold_en = 1'b0, hreq = 1'b0;
    logic req = 1'b0, we = 1'b0, sys_rst_n, rst_pin_o, rst_oe, ext_mode, ack, held;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata, p1_in, p0_o, p0_oe, p1_o, p1_oe, p2_o, p2_oe;
    logic [7:0]  m_ad, p0_pin, p1_pin, p2_pin, flt, p0_in, p2_in;
    logic [3:0]  wait_c = 4'h0;
    logic [15:0] m_addr;
    logic [7:0]  m_wdata;
    logic        m_en, m_rdy, buf_seen = 1'b0;
    int          n_mismatch = 0, total_checks = 0, cyc = 0, lat_f, lat_s;
    always #4 mclk_i = ~mclk_i;
    // Undriven lines change every cycle so a stale value cannot pass
    assign flt = cyc[0] ? 8'hA5 : 8'h5A;
    assign p0_pin = (p0_oe & p0_o) | (~p0_oe & (m_en ? m_ad : flt));
    assign p1_pin = (p1_oe & p1_o) | (~p1_oe & flt);
    assign p2_pin = (p2_oe & p2_o) | (~p2_oe & {flt[7:4], m_rdy, hreq, flt[1:0]});
    ext_bus_pin_mux dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .int_rst_i(int_rst_i),
        .sys_rst_n_o(sys_rst_n), .rst_pin_i(pin_low ? 1'b0 : (rst_oe ? rst_pin_o : 1'b1)),
        .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_oe), .op_select_pin_a_i(sel_a),
        .op_select_pin_b_i(sel_b), .ext_mode_o(ext_mode), .buf_en_i(buf_en),
        .hold_en_i(hold_en), .p0_out_i(8'h3C), .p0_dir_i(8'hF0), .p1_out_i(8'hC3),
        .p1_dir_i(8'hFF), .p2_out_i(8'h6F), .p0_in_o(p0_in), .p1_in_o(p1_in),
        .p2_in_o(p2_in),
        .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wdata), .ack_o(ack),
        .rdata_o(rdata), .held_o(held), .muxed_addr_data_pins_i(p0_pin),
        .muxed_addr_data_pins_o(p0_o), .muxed_addr_data_pins_oe(p0_oe),
        .high_address_pins_i(p1_pin), .high_address_pins_o(p1_o),
        .high_address_pins_oe(p1_oe), .p2_pins_i(p2_pin), .p2_pins_o(p2_o),
        .p2_pins_oe(p2_oe));
    bus_mem_model mem (.mclk_i(mclk_i), .ale_i(p2_oe[7] & p2_o[7]),
        .rd_n_i(~p2_oe[6] | p2_o[6]), .wr_n_i(~p2_oe[5] | p2_o[5]), .ad_i(p0_pin),
        .a_hi_i(p1_pin), .wait_i(wait_c), .ad_o(m_ad), .ad_en_o(m_en), .rdy_o(m_rdy),
        .last_addr_o(m_addr), .last_wdata_o(m_wdata));
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (p2_oe[0] && !p2_o[0]) begin
            buf_seen <= 1'b1;
        end
        if (cyc > 20000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bounded wait for sys reset (sel 0) or bus release (sel 1) to reach v
    task automatic wait_val(input string nm, input int sel, input logic v);
        logic s;
        for (int i = 0; i < 60; i++) begin
            @(negedge mclk_i);
            s = (sel == 0) ? sys_rst_n : held;
            if (s === v) begin
                break;
            end
        end
        check(nm, {15'h0000, s}, {15'h0000, v});
    endtask
    task automatic do_reset();
        @(negedge mclk_i);
        rst_n_i = 1'b0;
        repeat (10) @(negedge mclk_i);
        check("rst_oe", {15'h0000, rst_oe}, 16'h0001);
        check("rst_o", {15'h0000, rst_pin_o}, 16'h0000);
        rst_n_i = 1'b1;
        wait_val("sys_rst", 0, 1'b1);
        repeat (2) @(negedge mclk_i);
    endtask
    // Request held until ack is seen, dropped in the cycle of the ack
    task automatic bus_acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                           output int lat);
        @(negedge mclk_i);
        req = 1'b1;
        we = w;
        addr = a;
        wdata = d;
        lat = 0;
        do begin
            @(negedge mclk_i);
            lat = lat + 1;
        end while (ack !== 1'b1 && lat < 200);
        req = 1'b0;
        check("ack", {15'h0000, ack}, 16'h0001);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic b0;
        do_reset();
        check("mode", {15'h0000, ext_mode}, 16'h0000);
        check("p0_oe", {8'h00, p0_oe}, 16'h00F0);
        check("p0_o", {8'h00, p0_o & p0_oe}, 16'h0030);
        check("p1_o", {p1_oe, p1_o}, 16'hFFC3);
        check("p1_in", {8'h00, p1_in}, 16'h00C3);
        check("p2_o", {8'h00, p2_o}, 16'h006F);
        check("p0_in", {8'h00, p0_in}, {8'h00, 4'h3, flt[3:0]});
        check("p2_in", {8'h00, p2_in}, 16'h006F);
        @(negedge mclk_i);
        int_rst_i = 1'b1;
        @(negedge mclk_i);
        int_rst_i = 1'b0;
        check("int_sink", {14'h0000, rst_oe, rst_pin_o}, 16'h0002);
        wait_val("int_rec", 0, 1'b1);
        pin_low = 1'b1;
        repeat (6) @(negedge mclk_i);
        check("pin_rst", {15'h0000, sys_rst_n}, 16'h0000);
        pin_low = 1'b0;
        wait_val("pin_rec", 0, 1'b1);
        sel_a = 1'b1;
        do_reset();
        check("mode", {15'h0000, ext_mode}, 16'h0001);
        b0 = p2_o[4];
        @(negedge mclk_i);
        check("busclk", {15'h0000, p2_o[4]}, {15'h0000, ~b0});
        buf_seen = 1'b0;
        bus_acc(1'b1, 16'h12C4, 8'hA5, lat_f);
        check("w_addr", m_addr, 16'h12C4);
        check("w_data", {8'h00, m_wdata}, 16'h00A5);
        check("buf_on", {15'h0000, buf_seen}, 16'h0001);
        bus_acc(1'b1, 16'h3471, 8'h5E, lat_f);
        buf_en = 1'b0;
        buf_seen = 1'b0;
        wait_c = 4'h6;
        bus_acc(1'b0, 16'h12C4, 8'h00, lat_s);
        check("r_data", {8'h00, rdata}, 16'h00A5);
        check("buf_off", {15'h0000, buf_seen}, 16'h0000);
        check("stretch", {15'h0000, lat_s > lat_f + 4}, 16'h0001);
        wait_c = 4'h0;
        bus_acc(1'b0, 16'h3471, 8'h00, lat_f);
        check("r_data2", {8'h00, rdata}, 16'h005E);
        hreq = 1'b1;
        repeat (20) @(negedge mclk_i);
        check("no_hold", {15'h0000, held}, 16'h0000);
        hold_en = 1'b1;
        wait_val("held", 1, 1'b1);
        check("hack", {14'h0000, p2_oe[1], p2_o[1]}, 16'h0002);
        check("p0_free", {8'h00, p0_oe}, 16'h0000);
        hreq = 1'b0;
        wait_val("unheld", 1, 1'b0);
        bus_acc(1'b0, 16'h12C4, 8'h00, lat_f);
        check("r_data3", {8'h00, rdata}, 16'h00A5);
        conclude();
    end
endmodule
